// ### core/sdp_fifo.sv
// synchronous command fifo with valid/ready on both sides
`timescale 1ns/1ps
module sdp_fifo
  import sdp_pkg::*;
#(
  parameter int W     = 40,
  parameter int DEPTH = 8
)(
  input  wire logic    ref_clk_i,
  input  wire logic    rst_b_i,
  sdp_stream_if.fifo   st
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr_reg;
  logic [AW:0]  rd_ptr_reg;
  wire          full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                        (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire          empty = (wr_ptr_reg == rd_ptr_reg);
  wire          push  = st.in_valid && !full;
  wire          pop   = st.out_valid && st.out_ready;

  assign st.in_ready  = !full;
  assign st.out_valid = !empty;
  assign st.out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge ref_clk_i)
  begin
    if (push)
      mem[wr_ptr_reg[AW-1:0]] <= st.in_data;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule

// ### core/sdp_pkg.sv
// constants shared by the serial datagram slave port
package sdp_pkg;
  localparam int unsigned DGRAM_W  = 40;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned ADDR_W   = 7;
  localparam int unsigned STAT_W   = 8;
  localparam int unsigned DIR_BIT  = 39;
  localparam int unsigned ADDR_MSB = 38;
  localparam int unsigned ADDR_LSB = 32;
  localparam int unsigned CNT_W    = 6;
  localparam logic [5:0]  BIT_FULL = 6'h28;
  localparam int unsigned FIFO_DEPTH = 8;

  // register addresses as seen in the address byte
  localparam logic [6:0] REG_GLOBAL_STATUS   = 7'h01;
  localparam logic [6:0] REG_ACTUAL_POSITION = 7'h21;
  localparam logic [6:0] REG_VELOCITY_LIMIT  = 7'h27;
  localparam logic [7:0] WRITE_FLAG          = 8'h80;

  // returned flag byte layout
  localparam int unsigned ST_RSV   = 7;
  localparam int unsigned ST_STOP2 = 6;
  localparam int unsigned ST_STOP1 = 5;
  localparam int unsigned ST_VEL2  = 4;
  localparam int unsigned ST_VEL1  = 3;
  localparam int unsigned ST_DRV2  = 2;
  localparam int unsigned ST_DRV1  = 1;
  localparam int unsigned ST_RST   = 0;

  localparam logic [2:0]  GLOBAL_STATUS_REG_RESET = 3'h1;
  localparam logic [31:0] RESP_RESET  = 32'h0000_0000;
  localparam logic [7:0]  STAT_RESET  = 8'h00;

  // input glitch filter timing
  localparam int unsigned CLK_NS   = 40;
  localparam int unsigned FILT_NS  = 20;
  localparam int unsigned FILT_CYC_RAW = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned FILT_CYC = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;
  localparam logic [1:0]  FILT_CNT = FILT_CYC[1:0];

  // link pin indices inside the filter array
  localparam int unsigned PIN_SCK = 0;
  localparam int unsigned PIN_SDI = 1;
  localparam int unsigned PIN_CS  = 2;
  localparam int unsigned PIN_N   = 3;

  typedef enum logic [0:0] {LS_IDLE, LS_FRAME} sdp_link_state_t;
endpackage

// ### core/sdp_port.sv
// serial datagram slave port: link sampling, shifter, flag byte, command hand-off
//
// What this block does
// - each transfer is 40 bits, one address byte then four data bytes.
// - every register moves as a full 32-bit data field.
// - bit 39 set means write, clear means read; bits 38..32 address.
// - a read only records its address; its data bits are ignored.
// - every datagram returns data; after a read, the read register's contents.
// - after a write, the returned data equals the previous write data.
// - returned bits 39..32 carry the flag byte, not an address.
// - the flag byte is captured at each commit and sent next transfer.
// - flag bit 7 zero, bits 6..5 left stops, bits 4..3 velocity reached.
// - bits 2..1 driver errors, bit 0 reset seen; cleared by global status read.
// - data is right aligned, signed values two's complement.
// - chip select is active low and held low for the whole datagram.
// - input sampled on serial clock rise, output changes after its fall.
// - most significant bit travels first in both directions.
// - extra bits re-emerge on the output 40 clocks later.
// - chip select rising commits the shift register as the command if at least 40 bits arrived and the fifo has room.
// - with more than 40 bits, the last 40 form the command.
// - pulses shorter than 20 ns on the link inputs are ignored.
// - the serial clock idles high, clock polarity and phase both 1.
`timescale 1ns/1ps
module sdp_port
  import sdp_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              serial_clk_i,
  input  wire logic              serial_in_i,
  input  wire logic              chip_select_n_i,
  output logic                   serial_out_o,
  output logic                   serial_out_oe_b_o,
  input  wire logic [1:0]        stop_left_i,
  input  wire logic [1:0]        vel_reached_i,
  input  wire logic [1:0]        drv_err_i,
  input  wire logic              reg_ready_i,
  input  wire logic              reg_rdata_valid_i,
  input  wire logic [DATA_W-1:0] reg_rdata_i,
  output logic [ADDR_W-1:0]      reg_addr_o,
  output logic [DATA_W-1:0]      reg_wdata_o,
  output logic                   reg_wr_o,
  output logic                   reg_rd_o,
  output logic                   cmd_dropped_o
);
  // link pin sampling: two flops, then a stability filter per pin
  wire  [PIN_N-1:0] pin_raw = {chip_select_n_i, serial_in_i, serial_clk_i};
  logic [PIN_N-1:0] sync1_reg;
  logic [PIN_N-1:0] sync2_reg;
  logic [PIN_N-1:0] filt_reg;
  logic [PIN_N-1:0] filt_d_reg;
  logic [1:0]       fcnt_reg [PIN_N];

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++)
    begin : g_pin
      always_ff @(posedge ref_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          sync1_reg[gi]  <= 1'b1;
          sync2_reg[gi]  <= 1'b1;
          filt_reg[gi]   <= 1'b1;
          filt_d_reg[gi] <= 1'b1;
          fcnt_reg[gi]   <= 2'h0;
        end
        else
        begin
          sync1_reg[gi]  <= pin_raw[gi];
          sync2_reg[gi]  <= sync1_reg[gi];
          filt_d_reg[gi] <= filt_reg[gi];
          // a change must persist past the filter time before it counts
          if (sync2_reg[gi] == filt_reg[gi])
            fcnt_reg[gi] <= 2'h0;
          else if (fcnt_reg[gi] == FILT_CNT)
          begin
            filt_reg[gi] <= sync2_reg[gi];
            fcnt_reg[gi] <= 2'h0;
          end
          else
            fcnt_reg[gi] <= fcnt_reg[gi] + 2'h1;
        end
      end
    end
  endgenerate

  wire sdi_f    = filt_reg[PIN_SDI];
  wire sck_rise = filt_reg[PIN_SCK] && !filt_d_reg[PIN_SCK];
  wire sck_fall = !filt_reg[PIN_SCK] && filt_d_reg[PIN_SCK];
  wire cs_fall  = !filt_reg[PIN_CS] && filt_d_reg[PIN_CS];
  wire cs_rise  = filt_reg[PIN_CS] && !filt_d_reg[PIN_CS];

  sdp_link_state_t     state_reg;
  sdp_link_state_t     state_next;
  logic [DGRAM_W-1:0]  shift_reg;
  logic [CNT_W-1:0]    bit_cnt_reg;
  logic [STAT_W-1:0]   status_reg;
  logic [DATA_W-1:0]   resp_reg;
  logic [2:0]          global_status_reg_reg;
  logic [2:0]          global_status_reg_next;

  sdp_stream_if #(.W(DGRAM_W)) cmd_st ();

  sdp_fifo #(.W(DGRAM_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .st        (cmd_st.fifo)
  );

  // frame end decode
  wire frame_end  = cs_rise && (state_reg == LS_FRAME);
  wire frame_full = (bit_cnt_reg == BIT_FULL);
  wire commit_req = frame_end && frame_full;
  wire commit_ok  = commit_req && cmd_st.in_ready;
  wire cmd_write  = shift_reg[DIR_BIT];
  wire [ADDR_W-1:0] cmd_addr = shift_reg[ADDR_MSB:ADDR_LSB];
  wire [DATA_W-1:0] cmd_data = shift_reg[DATA_W-1:0];
  wire global_status_reg_rd   = commit_ok && !cmd_write && (cmd_addr == REG_GLOBAL_STATUS);

  // flag byte as it stands now; captured at each commit
  wire [STAT_W-1:0] status_now = {1'b0, stop_left_i[1], stop_left_i[0],
                                  vel_reached_i[1], vel_reached_i[0],
                                  global_status_reg_reg[ST_DRV2], global_status_reg_reg[ST_DRV1],
                                  global_status_reg_reg[ST_RST]};

  assign cmd_st.in_valid  = commit_req;
  assign cmd_st.in_data   = shift_reg;
  assign cmd_st.out_ready = reg_ready_i;

  wire pop     = cmd_st.out_valid && reg_ready_i;
  wire pop_wr  = cmd_st.out_data[DIR_BIT];

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      LS_IDLE:  if (cs_fall) state_next = LS_FRAME;
      LS_FRAME: if (cs_rise) state_next = LS_IDLE;
      default:  state_next = LS_IDLE;
    endcase
  end

  // flags set by events win over the clear from a global status read
  always_comb
  begin
    global_status_reg_next = global_status_reg_reg;
    if (global_status_reg_rd)
      global_status_reg_next = 3'h0;
    global_status_reg_next[ST_DRV2] = global_status_reg_next[ST_DRV2] | drv_err_i[1];
    global_status_reg_next[ST_DRV1] = global_status_reg_next[ST_DRV1] | drv_err_i[0];
  end

  // link-side shifter and output pin
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg         <= LS_IDLE;
      shift_reg         <= '0;
      bit_cnt_reg       <= '0;
      serial_out_o      <= 1'b0;
      serial_out_oe_b_o <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      if (cs_fall)
      begin
        shift_reg         <= {status_reg, resp_reg};
        bit_cnt_reg       <= '0;
        serial_out_o      <= status_reg[ST_RSV];
        serial_out_oe_b_o <= 1'b0;
      end
      else if (state_reg == LS_FRAME)
      begin
        if (sck_rise)
        begin
          shift_reg <= {shift_reg[DGRAM_W-2:0], sdi_f};
          if (!frame_full)
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
        end
        if (sck_fall)
          serial_out_o <= shift_reg[DGRAM_W-1];
        if (cs_rise)
          serial_out_oe_b_o <= 1'b1;
      end
    end
  end

  // flag byte, returned data and global status flags
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      status_reg <= STAT_RESET;
      resp_reg   <= RESP_RESET;
      global_status_reg_reg  <= GLOBAL_STATUS_REG_RESET;
    end
    else
    begin
      global_status_reg_reg <= global_status_reg_next;
      if (commit_ok)
        status_reg <= status_now;
      if (commit_ok && cmd_write)
        resp_reg <= cmd_data;
      else if (reg_rdata_valid_i)
        resp_reg <= reg_rdata_i;
    end
  end

  // command hand-off to the register file
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      reg_addr_o    <= '0;
      reg_wdata_o   <= '0;
      reg_wr_o      <= 1'b0;
      reg_rd_o      <= 1'b0;
      cmd_dropped_o <= 1'b0;
    end
    else
    begin
      reg_wr_o      <= pop && pop_wr;
      reg_rd_o      <= pop && !pop_wr;
      cmd_dropped_o <= commit_req && !cmd_st.in_ready;
      if (pop)
      begin
        reg_addr_o  <= cmd_st.out_data[ADDR_MSB:ADDR_LSB];
        reg_wdata_o <= cmd_st.out_data[DATA_W-1:0];
      end
    end
  end

  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence frame_open_s;
    cs_fall;
  endsequence

  sequence frame_commit_s;
    (state_reg == LS_FRAME) ##0 commit_ok;
  endsequence

  sequence read_pop_s;
    pop ##0 !pop_wr;
  endsequence

  frame_load_a: assert property (frame_open_s |=> shift_reg == $past({status_reg, resp_reg})
    && !serial_out_oe_b_o) else $error("frame start did not load flag byte and data");
  shift_in_a: assert property ((state_reg == LS_FRAME && sck_rise && !cs_fall) |=>
    shift_reg[0] == $past(sdi_f) && shift_reg[DGRAM_W-1:1] == $past(shift_reg[DGRAM_W-2:0]))
    else $error("serial input not shifted in on clock rise");
  out_change_a: assert property ($changed(serial_out_o) |-> $past(sck_fall || cs_fall))
    else $error("serial output changed outside a clock fall");
  status_capture_a: assert property (frame_commit_s |=> status_reg == $past(status_now)
    && status_reg[ST_RSV] == 1'b0) else $error("flag byte not captured at commit");
  write_mirror_a: assert property (frame_commit_s ##0 cmd_write |=> resp_reg == $past(cmd_data))
    else $error("write data not mirrored for next datagram");
  read_return_a: assert property ((reg_rdata_valid_i && !(commit_ok && cmd_write)) |=>
    resp_reg == $past(reg_rdata_i)) else $error("read data not loaded for return");
  read_nowrite_a: assert property (read_pop_s |=> reg_rd_o && !reg_wr_o)
    else $error("read request caused a register write");
  global_status_reg_clear_a: assert property ((global_status_reg_rd && drv_err_i == 2'h0) |=> global_status_reg_reg == 3'h0)
    else $error("global status read did not clear flags");
  short_frame_a: assert property ((frame_end && !frame_full) |-> !cmd_st.in_valid)
    else $error("short frame was committed");
  filter_hold_a: assert property ($changed(filt_reg[PIN_CS]) |->
    $past(fcnt_reg[PIN_CS]) == FILT_CNT) else $error("chip select passed filter early");
endmodule

// ### core/sdp_stream_if.sv
// valid/ready stream between the port logic and its command fifo
`timescale 1ns/1ps
interface sdp_stream_if #(parameter int W = 40);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, input in_data, input out_ready,
                output in_ready, output out_valid, output out_data);
  modport user (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data);
endinterface

// ### tb/sdp_host_model.sv
// serial master model that sends datagrams of up to 48 bits and collects the reply
`timescale 1ns/1ps
module sdp_host_model (
  input  wire logic ref_clk_i,
  input  wire logic line_i,
  output logic      serial_clk_o,
  output logic      serial_in_o,
  output logic      chip_select_n_o
);
  initial
  begin
    serial_clk_o    = 1'b1;
    serial_in_o     = 1'b0;
    chip_select_n_o = 1'b1;
  end

  // half a bit time is 4 system clocks, keeping well under half the system rate
  task automatic half();
    repeat (4) @(posedge ref_clk_i);
    #1;
  endtask

  // reply is sampled late in the high phase, after the output has settled
  task automatic xfer(input int nb, input logic [47:0] din, output logic [47:0] dout);
    dout = '0;
    chip_select_n_o = 1'b0;
    half();
    half();
    for (int i = nb - 1; i >= 0; i--)
    begin
      serial_clk_o = 1'b0;
      serial_in_o  = din[i];
      half();
      serial_clk_o = 1'b1;
      half();
      dout[i] = line_i;
    end
    chip_select_n_o = 1'b1;
    serial_in_o     = ~serial_in_o;
  endtask
endmodule

// ### tb/spi_datagram_slave_port_tb_top.sv
// self-checking bench for the serial datagram slave port
`timescale 1ns/1ps
module spi_datagram_slave_port_tb_top
  import sdp_pkg::*;
;
  logic              ref_clk_i, rst_b_i, sclk, sin, chip_select_n, sout, oe_b, line;
  logic [1:0]        stop_left_i, vel_reached_i, drv_err_i;
  logic              reg_ready_i, reg_rdata_valid_i, reg_wr_o, reg_rd_o;
  logic              cmd_dropped_o, stall, skip;
  logic [DATA_W-1:0] reg_rdata_i, reg_wdata_o, exp_data;
  logic [ADDR_W-1:0] reg_addr_o;
  logic [STAT_W-1:0] exp_stat;
  logic [2:0]        gflags;
  logic [39:0]       c;
  logic [DATA_W-1:0] mem [128];
  logic [39:0]       cmdq [$];
  int                err_count, total_checks, drops;

  // a released output line shows a pattern that changes every cycle
  assign line = oe_b ? ref_clk_i : sout;

  sdp_port sdp_port_inst (
    .ref_clk_i         (ref_clk_i),
    .rst_b_i           (rst_b_i),
    .serial_clk_i      (sclk),
    .serial_in_i       (sin),
    .chip_select_n_i   (chip_select_n),
    .serial_out_o      (sout),
    .serial_out_oe_b_o (oe_b),
    .stop_left_i       (stop_left_i),
    .vel_reached_i     (vel_reached_i),
    .drv_err_i         (drv_err_i),
    .reg_ready_i       (reg_ready_i),
    .reg_rdata_valid_i (reg_rdata_valid_i),
    .reg_rdata_i       (reg_rdata_i),
    .reg_addr_o        (reg_addr_o),
    .reg_wdata_o       (reg_wdata_o),
    .reg_wr_o          (reg_wr_o),
    .reg_rd_o          (reg_rd_o),
    .cmd_dropped_o     (cmd_dropped_o)
  );

  sdp_host_model sdp_host_model_inst (
    .ref_clk_i       (ref_clk_i),
    .line_i          (line),
    .serial_clk_o    (sclk),
    .serial_in_o     (sin),
    .chip_select_n_o (chip_select_n)
  );

  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string what, input logic [39:0] e, input logic [39:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wrap_up();
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // register file side: checks each strobe and answers reads one cycle later
  always @(posedge ref_clk_i)
  begin
    reg_rdata_valid_i <= 1'b0;
    reg_ready_i       <= ~stall & 1'($urandom);
    gflags[2:1] = gflags[2:1] | drv_err_i;
    if (reg_wr_o === 1'b1 || reg_rd_o === 1'b1)
    begin
      c = (cmdq.size() > 0) ? cmdq.pop_front() : '1;
      chk("strobe kind", 40'(c[39]), 40'(reg_wr_o));
      chk("address", 40'(c[38:32]), 40'(reg_addr_o));
      if (c[39]) chk("write data", 40'(c[31:0]), 40'(reg_wdata_o));
      reg_rdata_i       <= mem[c[38:32]];
      reg_rdata_valid_i <= reg_rd_o;
    end
    if (cmd_dropped_o === 1'b1) drops++;
  end

  task automatic flags();
    stop_left_i   = 2'($urandom);
    vel_reached_i = 2'($urandom);
    drv_err_i     = 2'($urandom);
    @(posedge ref_clk_i);
    #1;
    drv_err_i = 2'b00;
  endtask

  function automatic logic [47:0] rnd(input logic wr);
    logic [6:0] a [3] = '{REG_GLOBAL_STATUS, REG_ACTUAL_POSITION, REG_VELOCITY_LIMIT};
    return {8'($urandom), wr, a[$urandom % 3], 32'($urandom)};
  endfunction

  task automatic frame(input int nb, input logic [47:0] din);
    logic [47:0] got;
    logic [39:0] cmd;
    cmd = din[39:0];
    sdp_host_model_inst.xfer(nb, din, got);
    if (nb >= DGRAM_W)
    begin
      if (!skip) chk("response", {exp_stat, exp_data}, got[nb-1 -: 40]);
      if (nb > DGRAM_W) chk("chained bits", 40'(din[47:40]), 40'(got[7:0]));
      skip     = 1'b0;
      exp_stat = {1'b0, stop_left_i, vel_reached_i, gflags};
      if (cmd[39:32] == {1'b0, REG_GLOBAL_STATUS}) gflags = 3'h0;
      exp_data = cmd[39] ? cmd[31:0] : mem[cmd[38:32]];
      if (cmd[39]) mem[cmd[38:32]] = cmd[31:0];
      cmdq.push_back(cmd);
    end
    repeat (12) @(posedge ref_clk_i);
    #1;
  endtask

  initial
  begin
    void'($urandom(95932));
    rst_b_i = 1'b0;
    {stall, skip, reg_ready_i, reg_rdata_valid_i, reg_rdata_i} = '0;
    {stop_left_i, vel_reached_i, drv_err_i} = '0;
    {err_count, total_checks, drops} = '0;
    gflags   = GLOBAL_STATUS_REG_RESET;
    exp_stat = STAT_RESET;
    exp_data = RESP_RESET;
    foreach (mem[i]) mem[i] = '0;
    repeat (20) @(posedge ref_clk_i);
    #1;
    rst_b_i = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1;
    frame(40, {9'h000, REG_ACTUAL_POSITION, 32'($urandom)});
    frame(40, {WRITE_FLAG | {1'b0, REG_ACTUAL_POSITION}, 32'($urandom)});
    frame(40, {9'h000, REG_ACTUAL_POSITION, 32'h0});
    flags();
    frame(40, {9'h000, REG_GLOBAL_STATUS, 32'h0});
    frame(40, {9'h000, REG_GLOBAL_STATUS, 32'h0});
    frame(40, rnd(1'b1));
    for (int i = 0; i < 12; i++)
    begin
      flags();
      frame(40, rnd(1'($urandom)));
    end
    frame(48, rnd(1'b1));
    frame(20, rnd(1'b1));
    chk("queue after short", 40'(cmdq.size()), 40'd0);
    frame(40, rnd(1'b0));
    stall = 1'b1;
    for (int i = 0; i < 8; i++) frame(40, rnd(1'b1));
    frame(40, {WRITE_FLAG | {1'b0, REG_VELOCITY_LIMIT}, 32'($urandom)});
    void'(cmdq.pop_back());
    skip = 1'b1;
    chk("drops", 40'(drops), 40'd1);
    stall = 1'b0;
    repeat (40) @(posedge ref_clk_i);
    #1;
    chk("drained", 40'(cmdq.size()), 40'd0);
    frame(40, {WRITE_FLAG | {1'b0, REG_ACTUAL_POSITION}, 32'($urandom)});
    frame(40, {9'h000, REG_ACTUAL_POSITION, 32'h0});
    frame(40, {WRITE_FLAG | {1'b0, REG_ACTUAL_POSITION}, 32'($urandom)});
    wrap_up();
  end

  initial
  begin
    #2_000_000;
    err_count++;
    wrap_up();
  end
endmodule
